// ---- include/memory_space_decode_pkg.sv ----
/*
  Constants and carrier types for the address-space decoder.
  Assumes a 100 MHz system clock and one state time of three oscillator periods.
*/
package memory_space_decode_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned OSC_PER_STATE = 3;
  localparam int unsigned RESET_ENTRY_STATES = 2;
  localparam int unsigned FETCH_START_STATES = 10;

  localparam logic [15:0] PERIPH_LAST = 16'h0017;
  localparam logic [15:0] REG_SPACE_LAST = 16'h00ff;
  localparam logic [15:0] STANDBY_FIRST = 16'h00f0;
  localparam logic [15:0] PORT_REBUILD_LO = 16'h1ffe;
  localparam logic [15:0] PORT_REBUILD_HI = 16'h1fff;
  localparam logic [15:0] VECTOR_FIRST = 16'h2000;
  localparam logic [15:0] VECTOR_LAST = 16'h2011;
  localparam logic [15:0] FUTURE_FIRST = 16'h2012;
  localparam logic [15:0] FUTURE_LAST = 16'h2017;
  localparam logic [15:0] CONFIG_BYTE = 16'h2018;
  localparam logic [15:0] KEY_FIRST = 16'h2020;
  localparam logic [15:0] KEY_LAST = 16'h202f;
  localparam logic [15:0] RESET_ENTRY = 16'h2080;
  localparam logic [15:0] ROM_LAST_SMALL = 16'h3fff;
  localparam logic [15:0] ROM_LAST_LARGE = 16'h5fff;
  localparam logic [15:0] TIMERS_FORCE_ADDR = 16'h000c;

  localparam logic [15:0] WORD_ONLY_LO = 16'h0004;
  localparam logic [15:0] WORD_ONLY_HI = 16'h000c;
  localparam logic [15:0] ZERO_REG = 16'h0000;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] PHASE_LAST = 2'h2;

  typedef enum logic [2:0] {
    TGT_REGS, TGT_PERIPH, TGT_ROM, TGT_EXT, TGT_NONE
  } target_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic valid;
    target_e target;
    logic periph_rd;
    logic periph_wr;
    logic ram_we;
    logic bad_width;
    logic zero_read;
    logic vector;
    logic config_byte;
    logic key;
    logic port_rebuild;
  } mem_sel_s;

endpackage : memory_space_decode_pkg

// ---- rtl/memory_space_decode.sv ----
/*
  Address-space decoder, reset sequencer and standby RAM guard of the controller.
  Assumes requests and pins synchronous to i_sys_clk; i_osc_tick marks oscillator periods.
*/
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE1] Reads and writes decode peripheral registers separately
// [RULE2] Peripheral registers byte only, listed ones word only
// [RULE3] Zero register always reads as zero
// [RULE4] Software avoids reserved peripheral register locations
// [RULE5] Top sixteen RAM bytes survive on standby supply
// [RULE6] Fully in reset two state times after low
// [RULE7] Release reset two state times after oscillator stable
// [RULE8] First fetch at 2080H ten state times after release
// [RULE9] Reset held low at least two state times
// [RULE10] 1FFEH and 1FFFH stay ordinary external memory
// [RULE11] Nine vectors fetched from 2000H to 2011H
// [RULE12] Configuration byte 2018H, 2012H-2017H reserved
// [RULE13] Image fills reserved bytes 0FFH, 2019H holds 20H
// [RULE14] Security key occupies 2020H through 202FH
// [RULE15] Internal ROM only with ROM, select high, range
// [RULE16] Access select pin captured when reset rises
// [RULE17] No code in last three ROM locations
// [RULE18] Register addresses 00H-17H reach peripheral registers
// [RULE19] Fetches below 100H always go external
// [RULE20] One state time is three oscillator periods
module memory_space_decode
  import memory_space_decode_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_osc_tick,
  input wire logic i_reset_pin_b,
  input wire logic i_external_access_select,
  input wire logic i_has_rom,
  input wire logic i_large_rom,
  input wire mem_req_s i_req,
  output mem_sel_s o_sel,
  output logic o_in_reset,
  output logic o_fetch_start,
  output logic [15:0] o_fetch_addr,
  output logic o_ram_write_block,
  output logic o_state_tick
);

  typedef enum logic [1:0] {
    SEQ_RUN, SEQ_ENTER, SEQ_HELD, SEQ_LEAVE
  } seq_e;

  seq_e seq;
  logic [1:0] phase;
  logic [3:0] state_cnt;
  logic rom_enable;
  logic pin_q;
  logic state_tick;
  mem_sel_s next_sel;

  localparam int unsigned REGION_CNT = 4;
  localparam logic [15:0] REGION_LO [REGION_CNT] = '{
    VECTOR_FIRST, CONFIG_BYTE, KEY_FIRST, PORT_REBUILD_LO
  };
  localparam logic [15:0] REGION_HI [REGION_CNT] = '{
    VECTOR_LAST, CONFIG_BYTE, KEY_LAST, PORT_REBUILD_HI
  };
  logic [REGION_CNT-1:0] region_hit;

  // One comparator pair per special region
  for (genvar gi = 0; gi < REGION_CNT; gi++) begin : g_region
    assign region_hit[gi] = (i_req.addr >= REGION_LO[gi]) && (i_req.addr <= REGION_HI[gi]);
  end

  assign state_tick = i_osc_tick && (phase == PHASE_LAST);

  // State time from three oscillator periods
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      phase <= 2'h0;
      o_state_tick <= 1'b0;
    end else begin
      o_state_tick <= state_tick; // [RULE20]
      if (i_osc_tick) begin
        phase <= (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1; // [RULE20]
      end
    end
  end

  // Reset entry and exit sequencing
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      seq <= SEQ_HELD;
      state_cnt <= CNT_ZERO;
      o_in_reset <= 1'b1;
      o_ram_write_block <= 1'b1;
      o_fetch_start <= 1'b0;
      o_fetch_addr <= RESET_ENTRY;
    end else begin
      o_fetch_start <= 1'b0;
      case (seq)
        SEQ_RUN: begin
          if (!i_reset_pin_b) begin
            seq <= SEQ_ENTER;
            state_cnt <= CNT_ZERO;
            o_ram_write_block <= 1'b1; // [RULE6]
          end
        end
        SEQ_ENTER: begin
          if (i_reset_pin_b) begin
            seq <= SEQ_LEAVE; // [RULE9]
            state_cnt <= CNT_ZERO;
            o_in_reset <= 1'b1;
          end else if (state_tick) begin
            if (state_cnt == 4'(RESET_ENTRY_STATES - 1)) begin
              seq <= SEQ_HELD;
              o_in_reset <= 1'b1; // [RULE6]
            end
            state_cnt <= state_cnt + 4'h1;
          end
        end
        SEQ_HELD: begin
          if (i_reset_pin_b) begin
            seq <= SEQ_LEAVE; // [RULE7]
            state_cnt <= CNT_ZERO;
          end
        end
        SEQ_LEAVE: begin
          if (!i_reset_pin_b) begin
            seq <= SEQ_HELD;
            state_cnt <= CNT_ZERO;
          end else if (state_tick) begin
            if (state_cnt == 4'(FETCH_START_STATES - 1)) begin
              seq <= SEQ_RUN;
              o_in_reset <= 1'b0;
              o_ram_write_block <= 1'b0;
              o_fetch_start <= 1'b1; // [RULE8]
              o_fetch_addr <= RESET_ENTRY; // [RULE8]
            end
            state_cnt <= state_cnt + 4'h1;
          end
        end
        default: begin
          seq <= SEQ_HELD;
          o_in_reset <= 1'b1;
        end
      endcase
    end
  end

  // Access select caught on the reset pin rising
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pin_q <= 1'b0;
      rom_enable <= 1'b0;
    end else begin
      pin_q <= i_reset_pin_b;
      if (i_reset_pin_b && !pin_q) begin
        rom_enable <= i_external_access_select && i_has_rom; // [RULE16]
      end
    end
  end

  // Address decode
  always_comb begin
    logic [15:0] rom_last;
    logic in_rom;
    logic in_regs;
    logic in_periph;
    logic word_only;
    rom_last = i_large_rom ? ROM_LAST_LARGE : ROM_LAST_SMALL;
    in_rom = rom_enable && (i_req.addr >= VECTOR_FIRST)
      && (i_req.addr <= rom_last); // [RULE15]
    in_regs = (i_req.addr <= REG_SPACE_LAST);
    in_periph = (i_req.addr <= PERIPH_LAST); // [RULE18]
    word_only = in_periph && (i_req.addr == WORD_ONLY_LO || i_req.addr == WORD_ONLY_HI);
    next_sel = '0;
    next_sel.target = TGT_NONE;
    next_sel.valid = i_req.valid && !o_in_reset;
    if (next_sel.valid) begin
      if (i_req.fetch) begin
        next_sel.target = in_rom ? TGT_ROM : TGT_EXT; // [RULE19] [RULE15]
      end else if (in_periph && i_req.addr != ZERO_REG) begin
        next_sel.target = TGT_PERIPH;
        next_sel.periph_rd = !i_req.write; // [RULE1]
        next_sel.periph_wr = i_req.write; // [RULE1]
        next_sel.bad_width = word_only ? !i_req.word : i_req.word; // [RULE2]
        if (next_sel.bad_width) begin
          next_sel.periph_rd = 1'b0;
          next_sel.periph_wr = 1'b0;
        end
      end else if (in_regs) begin
        next_sel.target = TGT_REGS;
        next_sel.zero_read = (i_req.addr == ZERO_REG) && !i_req.write; // [RULE3]
        next_sel.ram_we = i_req.write && (i_req.addr != ZERO_REG)
          && !o_ram_write_block; // [RULE5] [RULE6]
      end else begin
        next_sel.target = in_rom ? TGT_ROM : TGT_EXT; // [RULE15]
      end
      next_sel.vector = region_hit[0]; // [RULE11]
      next_sel.config_byte = region_hit[1]; // [RULE12]
      next_sel.key = region_hit[2]; // [RULE14]
      next_sel.port_rebuild = region_hit[3]; // [RULE10]
    end
  end

  // Registered select
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_sel <= '0;
    end else begin
      o_sel <= next_sel;
    end
  end

endmodule // memory_space_decode

`default_nettype wire

// ---- sim/ext_memory_model.sv ----
/* External memory partner: counts accesses routed off chip.
   Assumes decode results arrive registered on o_sel. */
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model
  import memory_space_decode_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire mem_sel_s i_sel,
  output logic [15:0] o_ext_cnt
);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) o_ext_cnt <= 16'h0000;
    // Image content is the far side's duty
    else if (i_sel.valid && i_sel.target == TGT_EXT) o_ext_cnt <= o_ext_cnt + 16'h0001;
  end
endmodule // ext_memory_model
`default_nettype wire

// ---- sim/memory_space_decode_properties.sv ----
/* Checker for the address decoder top ports.
   Assumes i_osc_tick held high by the bench. */
`timescale 1ns/100ps
`default_nettype none
module memory_space_decode_properties
  import memory_space_decode_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_osc_tick,
  input wire logic i_reset_pin_b,
  input wire logic i_external_access_select,
  input wire logic i_has_rom,
  input wire logic i_large_rom,
  input wire mem_req_s i_req,
  input wire mem_sel_s o_sel,
  input wire logic o_in_reset,
  input wire logic o_fetch_start,
  input wire logic [15:0] o_fetch_addr,
  input wire logic o_ram_write_block,
  input wire logic o_state_tick
);
  logic pin_q;
  logic rom_en;
  logic [7:0] cnt;
  logic go;
  logic hit;
  logic rd;
  assign go = i_req.valid & ~o_in_reset & i_reset_pin_b;
  assign rd = go & ~i_req.write & ~i_req.fetch & ~i_req.word;
  assign hit = rom_en && i_req.addr >= 16'h2000
    && i_req.addr <= (i_large_rom ? 16'h5fff : 16'h3fff);
  always_ff @(posedge i_sys_clk) begin
    pin_q <= i_reset_pin_b;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) rom_en <= 1'b0;
    else if (i_reset_pin_b && !pin_q) rom_en <= i_external_access_select & i_has_rom;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || !i_reset_pin_b) cnt <= 8'h00;
    else if (o_in_reset && cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  zero_read_a: assert property (rd && i_req.addr == 16'h0000 |=> o_sel.zero_read)
    else $error("zero register read not flagged");
  periph_read_a: assert property (rd && i_req.addr inside {[16'h0001:16'h0017]}
    && !(i_req.addr inside {16'h0004, 16'h000c}) |=> o_sel.periph_rd && !o_sel.periph_wr)
    else $error("peripheral read strobe wrong");
  word_only_a: assert property (rd && i_req.addr inside {16'h0004, 16'h000c}
    |=> o_sel.bad_width && !o_sel.periph_rd)
    else $error("byte access to word register allowed");
  fetch_low_a: assert property (go && i_req.fetch && i_req.addr <= 16'h00ff
    |=> o_sel.target == TGT_EXT)
    else $error("low fetch not external");
  rom_pick_a: assert property (go && (i_req.fetch || i_req.addr > 16'h00ff)
    |=> o_sel.target == ($past(hit) ? TGT_ROM : TGT_EXT))
    else $error("rom or external choice wrong");
  ram_block_a: assert property (i_req.valid && o_ram_write_block |=> !o_sel.ram_we)
    else $error("ram write while blocked");
  enter_reset_a: assert property ($fell(i_reset_pin_b) && !o_in_reset
    |-> ##[1:2] o_ram_write_block ##[0:7] o_in_reset)
    else $error("reset entry too slow");
  fetch_start_a: assert property (o_fetch_start |-> o_fetch_addr == 16'h2080
    && cnt >= 8'd27 && cnt <= 8'd34)
    else $error("first fetch wrong");
  state_tick_a: assert property (o_state_tick && i_osc_tick
    |=> !o_state_tick ##1 !o_state_tick ##1 o_state_tick)
    else $error("state tick period wrong");
  cover property (o_fetch_start);
  cover property (o_sel.valid && o_sel.target == TGT_ROM);
  cover property (o_sel.bad_width);
endmodule // memory_space_decode_properties
`default_nettype wire

// ---- sim/test_memory_space_decode.sv ----
/* Self-checking bench for the address decoder.
   Assumes osc tick held high, so a state time is three clocks. */
`timescale 1ns/100ps
`default_nettype none
module test_memory_space_decode
  import memory_space_decode_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_osc_tick = 1'b1;
  logic i_reset_pin_b = 1'b0;
  logic i_external_access_select = 1'b1;
  logic i_has_rom = 1'b1;
  logic i_large_rom = 1'b0;
  mem_req_s i_req = '0;
  mem_sel_s o_sel;
  logic o_in_reset;
  logic o_fetch_start;
  logic [15:0] o_fetch_addr;
  logic o_ram_write_block;
  logic o_state_tick;
  logic [15:0] ext_cnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h1d73;
  int cyc = 0;
  int ext_exp = 0;
  int dir[8] = '{0, 4, 'hc, 2, 'h1ffe, 'h2018, 'h2005, 'h2027};
  memory_space_decode DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_osc_tick(i_osc_tick),
    .i_reset_pin_b(i_reset_pin_b), .i_external_access_select(i_external_access_select),
    .i_has_rom(i_has_rom), .i_large_rom(i_large_rom), .i_req(i_req), .o_sel(o_sel),
    .o_in_reset(o_in_reset), .o_fetch_start(o_fetch_start), .o_fetch_addr(o_fetch_addr),
    .o_ram_write_block(o_ram_write_block), .o_state_tick(o_state_tick));
  ext_memory_model ext_mem (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sel(o_sel),
    .o_ext_cnt(ext_cnt));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  function automatic target_e model(input int a, input bit f, input bit rom);
    if (!f && a <= 'hff) return (a <= 'h17 && a != 0) ? TGT_PERIPH : TGT_REGS;
    if (rom && a >= 'h2000 && a <= (i_large_rom ? 'h5fff : 'h3fff)) return TGT_ROM;
    return TGT_EXT;
  endfunction
  task automatic access(input int a, input bit f, input bit rom);
    target_e t;
    logic [3:0] fl;
    logic [3:0] sf;
    t = model(a, f, rom);
    fl[3] = a >= 'h2000 && a <= 'h2011;
    fl[2] = a == 'h2018;
    fl[1] = a >= 'h2020 && a <= 'h202f;
    fl[0] = a == 'h1ffe || a == 'h1fff;
    i_req = '{1'b1, 1'b0, f, 1'b0, a[15:0], 16'h0000};
    @(posedge i_sys_clk);
    #1;
    check(16'(o_sel.target), 16'(t));
    if (!f && a == 0) check(16'(o_sel.zero_read), 16'h0001);
    if (t == TGT_PERIPH) check(16'(o_sel.bad_width), 16'(a == 4 || a == 'hc));
    if (t == TGT_PERIPH) check(16'(o_sel.periph_rd), 16'(a != 4 && a != 'hc));
    sf = {o_sel.vector, o_sel.config_byte, o_sel.key, o_sel.port_rebuild};
    check(16'(sf), 16'(fl));
    if (t == TGT_EXT) ext_exp++;
  endtask
  task automatic phase(input bit s, input bit l, input bit h);
    int n;
    i_req = '{1'b1, 1'b1, 1'b0, 1'b0, 16'h00f0, 16'h00a5};
    i_reset_pin_b = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    check(16'(o_sel.target), 16'(TGT_NONE));
    check(16'(o_in_reset), 16'h0001);
    i_req.valid = 1'b0;
    i_external_access_select = s;
    i_large_rom = l;
    i_has_rom = h;
    i_reset_pin_b = 1'b1;
    n = 0;
    while (o_fetch_start !== 1'b1 && n < 60) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check(o_fetch_addr, 16'h2080);
    check(16'(n >= 27 && n <= 34), 16'h0001);
    i_external_access_select = ~s;
    foreach (dir[i]) access(dir[i], 1'b0, s & h);
    i_req = '{1'b1, 1'b1, 1'b0, 1'b0, 16'h00f0, 16'h005a};
    @(posedge i_sys_clk);
    #1;
    check(16'(o_sel.ram_we), 16'h0001);
    repeat (60) access($random(seed) & 'h70ff, $random(seed) & 1, s & h);
    i_req.valid = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
    phase(1'b1, 1'b0, 1'b1);
    phase(1'b1, 1'b1, 1'b1);
    phase(1'b0, 1'b1, 1'b1);
    phase(1'b1, 1'b0, 1'b0);
    @(posedge i_sys_clk);
    #1;
    check(ext_cnt, 16'(ext_exp));
    finish_test();
  end
endmodule // test_memory_space_decode
bind memory_space_decode memory_space_decode_properties chk (.*);
`default_nettype wire
